// ==== logic/pst_pkg.sv ====
// package for the supervisor timing block: offsets, fields, timing counts, types
// assumes a 125 MHz clock; all counts derive from times in their own units
package pst_pkg;
    localparam int CLK_KHZ = 125000;
    // times in their own units
    localparam int TIMEOUT_MS = 300;
    localparam int WD_WIN_OFF_US = 20000;
    localparam int WD_WIN_ON_US = 22000;
    localparam int WD_FILT_NS = 1200;
    localparam int RST_HOLD_US = 2000;
    localparam int ORDER_DLY_NS = 2000;
    localparam int BLK_US = 15;
    localparam int BLK_LONG_US = 30;
    localparam int GL_BLK_US = 10;
    localparam int UV_SLOW_US = 1000;
    localparam int SS_BOOST_MAX_US = 2700;
    localparam int SS_RAIL_MAX_US = 2000;
    // cycle counts
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
    localparam int WD_WIN_OFF_CYC = WD_WIN_OFF_US * (CLK_KHZ / 1000);
    localparam int WD_WIN_ON_CYC = WD_WIN_ON_US * (CLK_KHZ / 1000);
    localparam int WD_FILT_CYC = (WD_FILT_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int RST_HOLD_CYC = RST_HOLD_US * (CLK_KHZ / 1000);
    localparam int ORDER_DLY_CYC = ORDER_DLY_NS * (CLK_KHZ / 1000) / 1000;
    localparam int BLK_CYC = BLK_US * (CLK_KHZ / 1000);
    localparam int BLK_LONG_CYC = BLK_LONG_US * (CLK_KHZ / 1000);
    localparam int GL_BLK_CYC = GL_BLK_US * (CLK_KHZ / 1000);
    localparam int UV_SLOW_CYC = UV_SLOW_US * (CLK_KHZ / 1000);
    localparam int SS_BOOST_CYC = SS_BOOST_MAX_US * (CLK_KHZ / 1000);
    localparam int SS_RAIL_CYC = SS_RAIL_MAX_US * (CLK_KHZ / 1000);
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;
    // ctrl fields
    localparam int CTRL_SPREAD = 0;
    localparam int CTRL_LDO_OFF_EN = 1;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    // status event bits
    localparam int EV_WD_FAIL = 0;
    localparam int EV_WD_TIMEOUT = 1;
    localparam int EV_TSD = 2;
    localparam int EV_OTW = 3;
    localparam int EV_LDO_UV = 4;
    localparam int EV_BOOST_UV = 5;
    localparam int EV_LDO_OV = 6;
    localparam int EV_BOOST_OV = 7;
    localparam int EV_SS_FAIL = 8;
    localparam int EV_ERROR = 9;
    localparam int EV_N = 10;
    // filter index
    localparam int F_TSD = 0;
    localparam int F_OTW = 1;
    localparam int F_RST = 2;
    localparam int F_BUV = 3;
    localparam int F_IOUV = 4;
    localparam int F_BOV = 5;
    localparam int F_LUV = 6;
    localparam int F_BSUV = 7;
    localparam int F_LOV = 8;
    localparam int F_BSOV = 9;
    localparam int F_GL = 10;
    localparam int F_N = 11;
    // operating modes, as given by the sequencer
    typedef enum logic [2:0] {
        PST_OFF, PST_SELF_TEST_BEGIN, PST_SELF_TEST_END, PST_SENSOR_REF_CHECK,
        PST_RAMP, PST_ACTIVE, PST_ERROR
    } pst_mode_e;
    // reset output sequencer
    typedef enum logic [1:0] {PST_R_LOW, PST_R_HOLD, PST_R_IRQ, PST_R_UP} pst_rseq_e;
    // analogue monitor inputs
    typedef struct packed {
        logic tsd;
        logic otw;
        logic [2:0] buck_rails_uv;
        logic [2:0] buck_rails_ov;
        logic io_supply_rail_uv;
        logic ldo_uv;
        logic ldo_ov;
        logic boost_uv;
        logic boost_ov;
        logic gnd_loss;
    } pst_mon_s;
    // soft start progress
    typedef struct packed {
        logic boost_start;
        logic boost_good;
        logic [3:0] rail_start;
        logic [3:0] rail_good;
    } pst_ss_s;
endpackage

// ==== logic/pst_supervisor.sv ====
// supervisor timing: window watchdog, reset ordering, blanking filters, soft start
// assumes monitor inputs synchronous to clock; mode comes from the sequencer outside
// Notes on behaviour
// [R1] restart 300 ms timeout entering test/check/ramp
// [R2] active mode timeout starts at reset rise
// [R3] 20/22 ms window, first quarter closed
// [R4] trigger pulses under 1.2 us ignored
// [R5] system reset held low 2 ms
// [R6] peripheral reset rises 2 us after irq
// [R7] irq, peripheral reset fall 2 us after
// [R8] shutdown acts after 10-20 us blanking
// [R9] warning flagged after 10-20 us blanking
// [R10] rail uv/ov pulls reset after blanking
// [R11] buck uv 1 ms error; ldo/boost flag
// [R12] io rail uv error after blanking
// [R13] buck ov error; io rail no ov
// [R14] ldo/boost ov 20-40 us flag or error
// [R15] ground loss error after 5-20 us
// [R16] boost soft start within 0.7-2.7 ms; only the 2.7 ms limit is checked
// [R17] buck/ldo soft start within 0.5-2 ms; only the 2 ms limit is checked
`timescale 1ns/100ps
module pst_supervisor
    import pst_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // monitors and sequencer
    input wire pst_mon_s mon,
    input wire pst_ss_s ss,
    input wire pst_mode_e mode,
    input wire logic watchdog_trigger_pin,
    // outputs
    output logic system_reset_output,
    output logic peripheral_reset_output,
    output logic irq,
    output logic error_req,
    output logic shutdown_req,
    output logic ldo_off,
    output logic boost_off,
    output logic int_out
);
    // registers
    logic [31:0] ctrl; // spread spectrum and off enable
    logic [EV_N-1:0] status; // sticky events
    logic [EV_N-1:0] enable; // interrupt enables
    logic [EV_N-1:0] ev; // event pulses this cycle
    logic [F_N-1:0] raw; // unfiltered conditions
    logic [F_N-1:0] flt; // filtered conditions
    logic [F_N-1:0] flt_d; // previous filtered, for edges
    logic [F_N-1:0][17:0] fcnt; // filter counters
    logic [17:0] flim [F_N]; // filter limits
    logic apb_wr; // write strobe
    logic apb_rd; // read strobe
    logic next_error; // any cause of error state
    logic ss_fail; // any start ran over time
    // register write and read strobes
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // condition vector
    always_comb begin
        raw = '0;
        raw[F_TSD] = mon.tsd;
        raw[F_OTW] = mon.otw;
        raw[F_RST] = |mon.buck_rails_uv || |mon.buck_rails_ov || mon.io_supply_rail_uv;
        raw[F_BUV] = |mon.buck_rails_uv;
        raw[F_IOUV] = mon.io_supply_rail_uv;
        raw[F_BOV] = |mon.buck_rails_ov;
        raw[F_LUV] = mon.ldo_uv;
        raw[F_BSUV] = mon.boost_uv;
        raw[F_LOV] = mon.ldo_ov;
        raw[F_BSOV] = mon.boost_ov;
        raw[F_GL] = mon.gnd_loss;
    end

    // per-filter blanking lengths
    always_comb begin
        for (int i = 0; i < F_N; i++) begin
            flim[i] = 18'(BLK_CYC);
        end
        flim[F_BUV] = 18'(UV_SLOW_CYC); // R11
        flim[F_LUV] = 18'(UV_SLOW_CYC); // R11
        flim[F_BSUV] = 18'(UV_SLOW_CYC); // R11
        flim[F_LOV] = 18'(BLK_LONG_CYC); // R14
        flim[F_BSOV] = 18'(BLK_LONG_CYC); // R14
        flim[F_GL] = 18'(GL_BLK_CYC); // R15
    end

    // blanking filters: condition must persist for its limit
    always_ff @(posedge clock) begin
        if (srst) begin
            fcnt <= '0;
            flt <= '0;
            flt_d <= '0;
        end else begin
            flt_d <= flt;
            for (int i = 0; i < F_N; i++) begin
                if (!raw[i]) begin
                    fcnt[i] <= '0; // short excursions forgotten
                    flt[i] <= 1'b0;
                end else if (fcnt[i] >= flim[i] - 18'd1) begin
                    flt[i] <= 1'b1; // R8 R9 R10 R12 R13 R15
                end else begin
                    fcnt[i] <= fcnt[i] + 18'd1;
                end
            end
        end
    end

    // trigger glitch filter and edge
    logic [7:0] trig_cnt; // high time count
    logic trig_ok; // filtered trigger level
    logic trig_ok_d; // previous filtered level
    logic service; // one-cycle service event
    always_ff @(posedge clock) begin
        if (srst) begin
            trig_cnt <= '0;
            trig_ok <= 1'b0;
            trig_ok_d <= 1'b0;
        end else begin
            trig_ok_d <= trig_ok;
            if (!watchdog_trigger_pin) begin
                trig_cnt <= '0;
                trig_ok <= 1'b0;
            end else if (trig_cnt >= 8'(WD_FILT_CYC - 1)) begin
                trig_ok <= 1'b1; // R4
            end else begin
                trig_cnt <= trig_cnt + 8'd1;
            end
        end
    end
    assign service = trig_ok && !trig_ok_d;

    // window watchdog and mode timeout
    pst_mode_e mode_d; // previous mode
    logic [21:0] win_cnt; // position in window
    logic [21:0] win_len; // window length
    logic [27:0] to_cnt; // timeout counter
    logic to_run; // timeout counting
    logic in_tmode; // test, check or ramp
    logic sys_rise; // system reset rising
    assign in_tmode = mode == PST_SELF_TEST_BEGIN || mode == PST_SELF_TEST_END
        || mode == PST_SENSOR_REF_CHECK || mode == PST_RAMP;
    assign win_len = ctrl[CTRL_SPREAD] ? 22'(WD_WIN_ON_CYC) : 22'(WD_WIN_OFF_CYC); // R3
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_d <= PST_OFF;
            to_cnt <= '0;
            to_run <= 1'b0;
        end else begin
            mode_d <= mode;
            if (in_tmode && mode != mode_d) begin
                to_cnt <= '0; // R1
                to_run <= 1'b1;
            end else if (mode == PST_ACTIVE && mode_d != PST_ACTIVE) begin
                to_cnt <= '0; // wait for reset rise
                to_run <= 1'b0;
            end else if (mode == PST_ACTIVE && sys_rise) begin
                to_cnt <= '0; // R2
                to_run <= 1'b1;
            end else if (service && to_run && mode == PST_ACTIVE) begin
                to_cnt <= '0; // serviced
            end else if (to_run && to_cnt < 28'(TIMEOUT_CYC)) begin
                to_cnt <= to_cnt + 28'd1;
            end
            if (!in_tmode && mode != PST_ACTIVE) begin
                to_run <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (srst || mode != PST_ACTIVE || !system_reset_output) begin
            win_cnt <= '0;
        end else if (service || win_cnt >= win_len - 22'd1) begin
            win_cnt <= '0; // new window
        end else begin
            win_cnt <= win_cnt + 22'd1;
        end
    end

    // event pulses
    always_comb begin
        ev = '0;
        ev[EV_WD_FAIL] = mode == PST_ACTIVE && system_reset_output &&
            ((service && win_cnt < (win_len >> 2)) || win_cnt == win_len - 22'd1); // R3
        ev[EV_WD_TIMEOUT] = to_run && to_cnt == 28'(TIMEOUT_CYC) - 28'd1; // R1 R2
        ev[EV_TSD] = flt[F_TSD] && !flt_d[F_TSD]; // R8
        ev[EV_OTW] = flt[F_OTW] && !flt_d[F_OTW]; // R9
        ev[EV_LDO_UV] = flt[F_LUV] && !flt_d[F_LUV]; // R11
        ev[EV_BOOST_UV] = flt[F_BSUV] && !flt_d[F_BSUV]; // R11
        ev[EV_LDO_OV] = flt[F_LOV] && !flt_d[F_LOV]; // R14
        ev[EV_BOOST_OV] = flt[F_BSOV] && !flt_d[F_BSOV]; // R14
        ev[EV_SS_FAIL] = ss_fail;
        ev[EV_ERROR] = next_error && !error_req;
    end

    // error state request
    logic ov_ramp; // ldo/boost ov in check or ramp
    assign ov_ramp = (flt[F_LOV] || flt[F_BSOV])
        && (mode == PST_SENSOR_REF_CHECK || mode == PST_RAMP); // R14
    assign next_error = flt[F_BUV] || flt[F_IOUV] || flt[F_BOV] || flt[F_GL] || ov_ramp;
    always_ff @(posedge clock) begin
        if (srst) begin
            error_req <= 1'b0;
            shutdown_req <= 1'b0;
        end else begin
            error_req <= next_error; // R11 R12 R13 R15
            shutdown_req <= flt[F_TSD]; // R8
        end
    end

    // ldo and boost switch-off in active mode
    always_ff @(posedge clock) begin
        if (srst || mode != PST_ACTIVE) begin
            ldo_off <= 1'b0;
            boost_off <= 1'b0;
        end else if (ctrl[CTRL_LDO_OFF_EN]) begin
            if (flt[F_LOV] || flt[F_LUV]) ldo_off <= 1'b1; // R11 R14
            if (flt[F_BSOV] || flt[F_BSUV]) boost_off <= 1'b1; // R11 R14
        end
    end

    // soft start windows
    logic [18:0] ss_bcnt; // boost elapsed
    logic [3:0][18:0] ss_rcnt; // rail elapsed
    always_ff @(posedge clock) begin
        if (srst) begin
            ss_bcnt <= '0;
            ss_rcnt <= '0;
        end else begin
            if (!ss.boost_start || ss.boost_good) ss_bcnt <= '0;
            else if (ss_bcnt < 19'(SS_BOOST_CYC)) ss_bcnt <= ss_bcnt + 19'd1; // R16
            for (int i = 0; i < 4; i++) begin
                if (!ss.rail_start[i] || ss.rail_good[i]) ss_rcnt[i] <= '0;
                else if (ss_rcnt[i] < 19'(SS_RAIL_CYC)) ss_rcnt[i] <= ss_rcnt[i] + 19'd1; // R17
            end
        end
    end
    always_comb begin
        ss_fail = ss_bcnt == 19'(SS_BOOST_CYC) - 19'd1;
        for (int i = 0; i < 4; i++) begin
            if (ss_rcnt[i] == 19'(SS_RAIL_CYC) - 19'd1) ss_fail = 1'b1;
        end
    end

    // reset sequencer
    pst_rseq_e rseq; // sequencer state
    logic [17:0] rcnt; // hold and order counter
    logic [8:0] fcnt_d; // fall delay counter
    logic rst_cause; // reasons to hold reset low
    logic fall_pend; // waiting to drop irq side
    assign rst_cause = flt[F_RST] || ev[EV_WD_FAIL] || ev[EV_WD_TIMEOUT]
        || mode != PST_ACTIVE && mode != PST_RAMP || next_error; // R10
    assign sys_rise = rseq == PST_R_HOLD && rcnt >= 18'(RST_HOLD_CYC) - 18'd1 && !rst_cause;
    always_ff @(posedge clock) begin
        if (srst) begin
            rseq <= PST_R_LOW;
            rcnt <= '0;
            system_reset_output <= 1'b0;
            irq <= 1'b0;
            peripheral_reset_output <= 1'b0;
            fall_pend <= 1'b0;
            fcnt_d <= '0;
        end else begin
            if (rst_cause) begin
                rseq <= PST_R_LOW;
                rcnt <= '0;
                if (system_reset_output) begin
                    fall_pend <= 1'b1; // R7
                    fcnt_d <= '0;
                end
                system_reset_output <= 1'b0; // R10
            end else begin
                case (rseq)
                    PST_R_LOW: begin
                        rseq <= PST_R_HOLD;
                        rcnt <= '0;
                    end
                    PST_R_HOLD: begin
                        if (sys_rise) begin
                            system_reset_output <= 1'b1; // R5
                            rseq <= PST_R_IRQ;
                            rcnt <= '0;
                        end else begin
                            rcnt <= rcnt + 18'd1;
                        end
                    end
                    PST_R_IRQ: begin
                        irq <= 1'b1;
                        rseq <= PST_R_UP;
                        rcnt <= '0;
                    end
                    PST_R_UP: begin
                        if (rcnt == 18'(ORDER_DLY_CYC) - 18'd1) begin
                            peripheral_reset_output <= 1'b1; // R6
                        end
                        if (rcnt < 18'(ORDER_DLY_CYC)) rcnt <= rcnt + 18'd1;
                    end
                    default: rseq <= PST_R_LOW;
                endcase
            end
            if (fall_pend && !rst_cause) begin
                fall_pend <= fall_pend;
            end
            if (fall_pend) begin
                if (fcnt_d == 9'(ORDER_DLY_CYC) - 9'd1) begin
                    irq <= 1'b0; // R7
                    peripheral_reset_output <= 1'b0; // R7
                    fall_pend <= 1'b0;
                end else begin
                    fcnt_d <= fcnt_d + 9'd1;
                end
            end
        end
    end

    // apb registers and sticky status
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
            enable <= '0;
            status <= '0;
        end else begin
            if (apb_wr && paddr == OFS_CTRL) ctrl <= pwdata;
            if (apb_wr && paddr == OFS_ENABLE) enable <= pwdata[EV_N-1:0];
            if (apb_wr && paddr == OFS_CLEAR) begin
                status <= (status & ~pwdata[EV_N-1:0]) | ev; // set wins
            end else begin
                status <= status | ev;
            end
        end
    end

    // read data, one cycle answer
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (apb_rd) begin
                if (paddr == OFS_CTRL) prdata <= ctrl;
                else if (paddr == OFS_STATUS) prdata <= 32'(status);
                else if (paddr == OFS_ENABLE) prdata <= 32'(enable);
                else if (paddr == OFS_STATE) prdata <= 32'({rseq, mode});
                else if (paddr == OFS_CLEAR) prdata <= '0;
                else begin
                    prdata <= '0;
                    pslverr <= 1'b1; // unmapped
                end
            end
        end
    end

    // interrupt level: high while an enabled status bit is set
    always_ff @(posedge clock) begin
        if (srst) int_out <= 1'b0;
        else int_out <= |(status & enable);
    end
endmodule

// ==== bench/pst_supervisor_checker.sv ====
// checker: timing relations seen at the supervisor ports
// assumes a bind onto pst_supervisor; one clock domain, srst synchronous
`timescale 1ns/100ps
module pst_supervisor_checker
    import pst_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // watched inputs
    input wire pst_mon_s mon,
    input wire pst_mode_e mode,
    // watched outputs
    input wire logic system_reset_output,
    input wire logic peripheral_reset_output,
    input wire logic irq,
    input wire logic error_req,
    input wire logic shutdown_req
);
    // shortest legal hold of the reset low, in cycles
    localparam int HOLD_MIN = 225000;
    // cycles each condition has stood without a break
    int c_lo, c_tsd, c_rail, c_io, c_gl, c_bov, c_lov;
    // any buck fault or io rail sag
    wire logic rail_bad = |{mon.buck_rails_uv, mon.buck_rails_ov, mon.io_supply_rail_uv};
    // run-length counters, cleared by reset or a break
    always_ff @(posedge clock) begin
        c_lo <= (srst || system_reset_output) ? 0 : c_lo + 1;
        c_tsd <= (srst || !mon.tsd) ? 0 : c_tsd + 1;
        c_rail <= (srst || !rail_bad) ? 0 : c_rail + 1;
        c_io <= (srst || !mon.io_supply_rail_uv) ? 0 : c_io + 1;
        c_gl <= (srst || !mon.gnd_loss) ? 0 : c_gl + 1;
        c_bov <= (srst || !(|mon.buck_rails_ov)) ? 0 : c_bov + 1;
        c_lov <= (srst || !(mon.ldo_ov || mon.boost_ov)) ? 0 : c_lov + 1;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    property p_irq_follow;
        $rose(system_reset_output) |-> ##[1:2] irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq not after reset");
    property p_pres_late;
        $rose(peripheral_reset_output) |-> $past(irq, 240);
    endproperty
    a_pres_late: assert property (p_pres_late) else $error("periph reset early");
    property p_pres_rise;
        $rose(irq) |-> ##[240:260] peripheral_reset_output;
    endproperty
    a_pres_rise: assert property (p_pres_rise) else $error("periph reset late");
    property p_fall;
        $fell(system_reset_output) |-> ##[240:260] (!irq && !peripheral_reset_output);
    endproperty
    a_fall: assert property (p_fall) else $error("irq or periph reset stuck");
    property p_hold;
        $rose(system_reset_output) |-> c_lo >= HOLD_MIN;
    endproperty
    a_hold: assert property (p_hold) else $error("reset hold short");
    property p_tsd_lo;
        $rose(shutdown_req) |-> c_tsd >= 1250;
    endproperty
    a_tsd_lo: assert property (p_tsd_lo) else $error("shutdown too soon");
    property p_tsd_hi;
        c_tsd == 2510 |-> shutdown_req;
    endproperty
    a_tsd_hi: assert property (p_tsd_hi) else $error("shutdown late");
    property p_rail;
        c_rail == 2510 |-> !system_reset_output;
    endproperty
    a_rail: assert property (p_rail) else $error("reset not pulled");
    property p_io;
        c_io == 2510 |-> error_req;
    endproperty
    a_io: assert property (p_io) else $error("io sag no error");
    property p_gl;
        c_gl == 2510 |-> error_req;
    endproperty
    a_gl: assert property (p_gl) else $error("ground loss no error");
    property p_bov;
        c_bov == 2510 |-> error_req;
    endproperty
    a_bov: assert property (p_bov) else $error("buck ov no error");
    property p_lov;
        c_lov == 5010 && mode inside {PST_RAMP, PST_SENSOR_REF_CHECK} |-> error_req;
    endproperty
    a_lov: assert property (p_lov) else $error("ov in ramp no error");
endmodule

// ==== bench/pst_host_model.sv ====
// host model: pulses the watchdog trigger for a commanded width
// assumes the testbench decides when a service falls in the open window
`timescale 1ns/100ps
module pst_host_model (
    // clock
    input wire logic clock,
    // service command
    input wire logic kick,
    input wire logic [15:0] width,
    // trigger pin, pulled down when idle
    output logic watchdog_trigger_pin
);
    // cycles of trigger still to drive
    logic [15:0] left = 16'h0000;
    // load on a command, count down otherwise
    always_ff @(posedge clock) begin
        if (kick) begin
            left <= width;
        end else if (left != 16'h0000) begin
            left <= left - 16'h0001;
        end
    end
    assign watchdog_trigger_pin = (left != 16'h0000);
endmodule

// ==== bench/pst_supervisor_test.sv ====
// testbench: apb register checks and blanking filters of the supervisor
// assumes package, design, host model and checker are compiled first
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module pst_supervisor_test
    import pst_pkg::*;
;
    // stimulus and observed signals
    logic clock, srst, psel, penable, pwrite, kick, wd_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] width;
    logic pready, pslverr, er, sro, pro, irq, err_o, sd_o, ldo_off, boost_off, int_o;
    pst_mon_s mon;
    pst_ss_s ss;
    pst_mode_e mode;
    int err_total, comparisons, cycles;
    // glitch and full lengths per case
    localparam int SHORT_N [7] = '{1000, 500, 1000, 1000, 2000, 2000, 1000};
    localparam int LONG_N [7] = '{2600, 2600, 2600, 2600, 5100, 5100, 2600};
    localparam logic LONG_EXP [7] = '{1, 1, 1, 1, 1, 1, 0};
    pst_supervisor uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mon(mon), .ss(ss), .mode(mode),
        .watchdog_trigger_pin(wd_pin), .system_reset_output(sro),
        .peripheral_reset_output(pro), .irq(irq), .error_req(err_o),
        .shutdown_req(sd_o), .ldo_off(ldo_off), .boost_off(boost_off), .int_out(int_o));
    pst_host_model host (.clock(clock), .kick(kick), .width(width),
        .watchdog_trigger_pin(wd_pin));
    // clock generator
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // verdict and end of run
    task complete_run();
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end
    // one apb transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // read and compare a register
    task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h00000000);
        `CHK("register", ex, rd)
    endtask
    // reset held 8 cycles, monitors quiet
    task rst();
        srst <= 1'b1;
        mon <= '0;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
    endtask
    // drive a monitor pattern for n cycles
    task hold(input pst_mon_s m, input int n);
        mon <= m;
        repeat (n) @(posedge clock);
    endtask
    // fault pattern of each case
    function automatic pst_mon_s mk(int k);
        pst_mon_s m;
        m = '0;
        case (k)
            0: m.tsd = 1'b1;
            1: m.gnd_loss = 1'b1;
            2: m.io_supply_rail_uv = 1'b1;
            3: m.buck_rails_ov = 3'h4;
            4: m.boost_ov = 1'b1;
            5: m.ldo_ov = 1'b1;
            default: m.buck_rails_uv = 3'h1;
        endcase
        return m;
    endfunction
    // output watched by each case
    function automatic logic pick(int k);
        return (k == 0) ? sd_o : err_o;
    endfunction
    // main sequence
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        mon = '0;
        ss = '0;
        mode = PST_ACTIVE;
        kick = 1'b0;
        width = 16'h0000;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        rst();
        // reset values and access kinds
        rchk(OFS_CTRL, CTRL_RESET);
        rchk(OFS_STATUS, 32'h00000000);
        rchk(OFS_ENABLE, 32'h00000000);
        rchk(OFS_STATE, 32'({PST_R_HOLD, PST_ACTIVE}));
        `CHK("reset out", 1'b0, sro)
        apb(1'b1, OFS_CTRL, 32'h00000003);
        rchk(OFS_CTRL, 32'h00000003);
        apb(1'b1, OFS_ENABLE, 32'h000003FF);
        rchk(OFS_ENABLE, 32'h000003FF);
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        rchk(OFS_STATUS, 32'h00000000);
        apb(1'b0, 8'h20, 32'h00000000);
        `CHK("unmapped", 1'b1, er)
        // glitch then long warning, then clear
        hold(14'h1000, 1000);
        rchk(OFS_STATUS, 32'h00000000);
        hold(14'h1000, 2600);
        mon <= '0;
        rchk(OFS_STATUS, 32'h00000008);
        `CHK("int", 1'b1, int_o)
        apb(1'b1, OFS_CLEAR, 32'h00000008);
        rchk(OFS_STATUS, 32'h00000000);
        `CHK("int clear", 1'b0, int_o)
        // short trigger while reset is low: no watchdog event
        kick <= 1'b1;
        width <= 16'h0064;
        @(posedge clock);
        kick <= 1'b0;
        repeat (300) @(posedge clock);
        rchk(OFS_STATUS, 32'h00000000);
        // ldo and boost overvoltage in active mode
        hold(14'h000A, 2000);
        `CHK("ldo off early", 1'b0, ldo_off)
        hold(14'h000A, 5100);
        `CHK("ldo off", 1'b1, ldo_off)
        `CHK("boost off", 1'b1, boost_off)
        mon <= '0;
        rchk(OFS_STATUS, 32'h000000C0);
        // blanking of each fault: glitch ignored, long one acts except buck uv (2600 cycles, under its 1 ms blanking)
        for (int k = 0; k < 7; k++) begin
            rst();
            mode <= (k == 4) ? PST_RAMP : ((k == 5) ? PST_SENSOR_REF_CHECK : PST_ACTIVE);
            hold(mk(k), SHORT_N[k]);
            `CHK("glitch", 1'b0, pick(k))
            mon <= '0;
            repeat (4) @(posedge clock);
            hold(mk(k), LONG_N[k]);
            `CHK("blanked", LONG_EXP[k], pick(k))
            `CHK("reset low", 1'b0, sro)
        end
        complete_run();
    end
endmodule
bind pst_supervisor pst_supervisor_checker chk (.clock(clock), .srst(srst), .mon(mon),
    .mode(mode), .system_reset_output(system_reset_output),
    .peripheral_reset_output(peripheral_reset_output), .irq(irq),
    .error_req(error_req), .shutdown_req(shutdown_req));
